// file: rtl/psr_pkg.sv
// Package of offsets, field positions, reset values and masks for the peripheral soft reset block.
`default_nettype none

package psr_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int unsigned PSR_ADDR_W = 12;
  localparam int unsigned PSR_DATA_W = 32;

  // ************************************************************
  // Register offsets from the system-control base
  // ************************************************************
  localparam logic [PSR_ADDR_W-1:0] PSR_OFF_PERIPH_RESET = 12'h044;
  localparam logic [PSR_ADDR_W-1:0] PSR_OFF_PORT_RESET   = 12'h048;
  // Read-only views of the capability masks, so software can see what a write may touch.
  localparam logic [PSR_ADDR_W-1:0] PSR_OFF_PERIPH_CAPS  = 12'h0F0;
  localparam logic [PSR_ADDR_W-1:0] PSR_OFF_PORT_CAPS    = 12'h0F4;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [PSR_DATA_W-1:0] PSR_RST_PERIPH_RESET = 32'h0000_0000;
  localparam logic [PSR_DATA_W-1:0] PSR_RST_PORT_RESET   = 32'h0000_0000;
  localparam logic [PSR_DATA_W-1:0] PSR_RDATA_IDLE       = 32'h0000_0000;

  // ************************************************************
  // Field positions in the peripheral reset register
  // ************************************************************
  localparam int unsigned PSR_BIT_COMPARATOR_ZERO = 24;
  localparam int unsigned PSR_BIT_GP_COUNTER_TWO  = 18;
  localparam int unsigned PSR_BIT_GP_COUNTER_ONE  = 17;
  localparam int unsigned PSR_BIT_GP_COUNTER_ZERO = 16;
  localparam int unsigned PSR_BIT_TWO_WIRE_ZERO   = 12;
  localparam int unsigned PSR_BIT_SYNC_SERIAL     = 4;
  localparam int unsigned PSR_BIT_ASYNC_ONE       = 1;
  localparam int unsigned PSR_BIT_ASYNC_ZERO      = 0;

  // ************************************************************
  // Field positions in the port reset register
  // ************************************************************
  localparam int unsigned PSR_BIT_PORT_E = 4;
  localparam int unsigned PSR_BIT_PORT_D = 3;
  localparam int unsigned PSR_BIT_PORT_C = 2;
  localparam int unsigned PSR_BIT_PORT_B = 1;
  localparam int unsigned PSR_BIT_PORT_A = 0;

  // ************************************************************
  // Implemented bits; every other position is read-only zero
  // ************************************************************
  localparam logic [PSR_DATA_W-1:0] PSR_IMPL_PERIPH_RESET = 32'h0107_1013;
  localparam logic [PSR_DATA_W-1:0] PSR_IMPL_PORT_RESET   = 32'h0000_001F;

endpackage : psr_pkg

`default_nettype wire

// file: rtl/psr_masked_reg.sv
// Register cell whose bits take a write only where implemented and reported present.
`default_nettype none

module psr_masked_reg
  import psr_pkg::*;
#(
  parameter int unsigned                WIDTH     = PSR_DATA_W,
  parameter logic [PSR_DATA_W-1:0]      IMPL_MASK = PSR_IMPL_PORT_RESET,
  parameter logic [PSR_DATA_W-1:0]      RST_VALUE = PSR_RST_PORT_RESET
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Write request.
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wdata,
  // Capability mask from the device.
  input  wire logic [WIDTH-1:0] presence,
  // Stored value.
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] next_q;

  // ************************************************************
  // Per-bit update
  // ************************************************************
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      if (IMPL_MASK[i]) begin : g_impl
        // A bit of an absent peripheral keeps its value, so it stays zero from reset on.
        always_comb begin
          if (wr_en && presence[i]) begin
            next_q[i] = wdata[i];
          end else begin
            next_q[i] = q[i];
          end
        end
      end else begin : g_rsvd
        // Reserved positions hold no storage and read as zero.
        always_comb begin
          next_q[i] = 1'b0;
        end
      end
    end
  endgenerate

  // The register itself; synchronous reset to the documented value.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= RST_VALUE[WIDTH-1:0];
    end else begin
      q <= next_q;
    end
  end

endmodule : psr_masked_reg

`default_nettype wire

// file: rtl/psr_ctrl.sv
// Peripheral soft reset controller: two masked reset-control registers and their reset lines.
`default_nettype none

// Summary of operation
// - Writes only land on present-peripheral bits.
// - Peripheral reset register at 0x044, resets zero.
// - Port reset register at 0x048, resets zero.
// - Bit 24 resets comparator zero.
// - Bits 18..16 reset counters two, one, zero.
// - Bit 12 resets two-wire unit zero.
// - Bit 4 resets synchronous serial unit.
// - Bits 1..0 reset asynchronous serial one, zero.
// - Port register bits 4..0 reset ports E..A.
// - Unassigned bits are read-only zero.
module psr_ctrl
  import psr_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Register port.
  input  wire logic [PSR_ADDR_W-1:0] reg_addr,
  input  wire logic [PSR_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output var  logic [PSR_DATA_W-1:0] reg_rdata,
  // Device capability masks.
  input  wire logic [PSR_DATA_W-1:0] peripheral_presence_mask,
  input  wire logic [PSR_DATA_W-1:0] port_presence_mask,
  // Peripheral reset lines, active high.
  output var  logic                  comparator_zero_reset,
  output var  logic                  gp_counter_zero_reset,
  output var  logic                  gp_counter_one_reset,
  output var  logic                  gp_counter_two_reset,
  output var  logic                  two_wire_zero_reset,
  output var  logic                  sync_serial_zero_reset,
  output var  logic                  async_serial_zero_reset,
  output var  logic                  async_serial_one_reset,
  // Port reset lines, active high.
  output var  logic                  port_a_reset,
  output var  logic                  port_b_reset,
  output var  logic                  port_c_reset,
  output var  logic                  port_d_reset,
  output var  logic                  port_e_reset
);

  // ************************************************************
  // Address decode
  // ************************************************************

  logic                  hit_periph;
  logic                  hit_port;
  logic                  hit_periph_caps;
  logic                  hit_port_caps;
  logic                  wr_periph;
  logic                  wr_port;

  // Full-width compare; a near miss of an offset must not alias onto a register.
  always_comb begin
    hit_periph      = (reg_addr == PSR_OFF_PERIPH_RESET);
    hit_port        = (reg_addr == PSR_OFF_PORT_RESET);
    hit_periph_caps = (reg_addr == PSR_OFF_PERIPH_CAPS);
    hit_port_caps   = (reg_addr == PSR_OFF_PORT_CAPS);
  end

  // A write strobe only acts on the register it addresses; the capability views ignore writes.
  always_comb begin
    wr_periph = reg_wr && hit_periph;
    wr_port   = reg_wr && hit_port;
  end

  // ************************************************************
  // Reset-control registers
  // ************************************************************

  logic [PSR_DATA_W-1:0] periph_reset_q;
  logic [PSR_DATA_W-1:0] port_reset_q;

  // Peripheral reset register; only the eight implemented fields have storage.
  psr_masked_reg #(
    .WIDTH     (PSR_DATA_W),
    .IMPL_MASK (PSR_IMPL_PERIPH_RESET),
    .RST_VALUE (PSR_RST_PERIPH_RESET)
  ) u_periph_reset (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .wr_en    (wr_periph),
    .wdata    (reg_wdata),
    .presence (peripheral_presence_mask),
    .q        (periph_reset_q)
  );

  // Port reset register; ports A to E in the low five bits.
  psr_masked_reg #(
    .WIDTH     (PSR_DATA_W),
    .IMPL_MASK (PSR_IMPL_PORT_RESET),
    .RST_VALUE (PSR_RST_PORT_RESET)
  ) u_port_reset (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .wr_en    (wr_port),
    .wdata    (reg_wdata),
    .presence (port_presence_mask),
    .q        (port_reset_q)
  );

  // ************************************************************
  // Peripheral reset lines
  // ************************************************************

  // Each line is the stored bit itself, so it comes straight from a flip-flop and cannot glitch.
  // A peripheral sits in reset for as long as its bit reads one.
  always_comb begin
    comparator_zero_reset   = periph_reset_q[PSR_BIT_COMPARATOR_ZERO];
    gp_counter_two_reset    = periph_reset_q[PSR_BIT_GP_COUNTER_TWO];
    gp_counter_one_reset    = periph_reset_q[PSR_BIT_GP_COUNTER_ONE];
    gp_counter_zero_reset   = periph_reset_q[PSR_BIT_GP_COUNTER_ZERO];
    two_wire_zero_reset     = periph_reset_q[PSR_BIT_TWO_WIRE_ZERO];
    sync_serial_zero_reset  = periph_reset_q[PSR_BIT_SYNC_SERIAL];
    async_serial_one_reset  = periph_reset_q[PSR_BIT_ASYNC_ONE];
    async_serial_zero_reset = periph_reset_q[PSR_BIT_ASYNC_ZERO];
  end

  // ************************************************************
  // Port reset lines
  // ************************************************************

  // Same scheme as above: one stored bit per port, held for as long as software leaves it set.
  always_comb begin
    port_e_reset = port_reset_q[PSR_BIT_PORT_E];
    port_d_reset = port_reset_q[PSR_BIT_PORT_D];
    port_c_reset = port_reset_q[PSR_BIT_PORT_C];
    port_b_reset = port_reset_q[PSR_BIT_PORT_B];
    port_a_reset = port_reset_q[PSR_BIT_PORT_A];
  end

  // ************************************************************
  // Read path
  // ************************************************************

  logic [PSR_DATA_W-1:0] next_rdata;

  // Read data are valid only in the cycle after the strobe; the rest of the time the port
  // idles at zero so a late sample by the master shows up clearly instead of as stale data.
  // Software is expected to read, modify and write back whole words; reserved bits then
  // return as zero and are written back as zero, which the register ignores anyway.
  always_comb begin
    next_rdata = PSR_RDATA_IDLE;
    if (reg_rd) begin
      if (hit_periph) begin
        next_rdata = periph_reset_q & PSR_IMPL_PERIPH_RESET;
      end else if (hit_port) begin
        next_rdata = port_reset_q & PSR_IMPL_PORT_RESET;
      end else if (hit_periph_caps) begin
        next_rdata = peripheral_presence_mask & PSR_IMPL_PERIPH_RESET;
      end else if (hit_port_caps) begin
        next_rdata = port_presence_mask & PSR_IMPL_PORT_RESET;
      end else begin
        next_rdata = PSR_RDATA_IDLE;                              // Unmapped reads return zero.
      end
    end
  end

  // Registered read data; the slave never stalls the master.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= PSR_RDATA_IDLE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : psr_ctrl

`default_nettype wire

// file: dv/psr_ctrl_monitor.sv
// Checker of register reads, masked writes and reset lines of the soft reset block.
`default_nettype none
module psr_ctrl_monitor
  import psr_pkg::*;
(
  // Clock, reset and register port.
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic [PSR_ADDR_W-1:0] reg_addr,
  input wire logic [PSR_DATA_W-1:0] reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [PSR_DATA_W-1:0] reg_rdata,
  // Capability masks.
  input wire logic [PSR_DATA_W-1:0] peripheral_presence_mask,
  input wire logic [PSR_DATA_W-1:0] port_presence_mask,
  // Reset lines.
  input wire logic                  comparator_zero_reset,
  input wire logic                  gp_counter_zero_reset,
  input wire logic                  gp_counter_one_reset,
  input wire logic                  gp_counter_two_reset,
  input wire logic                  two_wire_zero_reset,
  input wire logic                  sync_serial_zero_reset,
  input wire logic                  async_serial_zero_reset,
  input wire logic                  async_serial_one_reset,
  input wire logic                  port_a_reset,
  input wire logic                  port_b_reset,
  input wire logic                  port_c_reset,
  input wire logic                  port_d_reset,
  input wire logic                  port_e_reset
);
  // ****
  // Register images rebuilt from the reset lines.
  // ****
  wire logic [31:0] pv = {7'h0, comparator_zero_reset, 5'h0, gp_counter_two_reset, gp_counter_one_reset,
    gp_counter_zero_reset, 3'h0, two_wire_zero_reset, 7'h0, sync_serial_zero_reset, 2'h0,
    async_serial_one_reset, async_serial_zero_reset};
  wire logic [31:0] pt = {27'h0, port_e_reset, port_d_reset, port_c_reset, port_b_reset, port_a_reset};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // A write is a request step followed by the landing step.
  sequence s_per_wr;
    reg_wr && reg_addr == PSR_OFF_PERIPH_RESET;
  endsequence
  sequence s_port_wr;
    reg_wr && reg_addr == PSR_OFF_PORT_RESET;
  endsequence
  wr_periph_a: assert property (s_per_wr |=> pv == ((($past(reg_wdata) & $past(peripheral_presence_mask))
    | ($past(pv) & ~$past(peripheral_presence_mask))) & PSR_IMPL_PERIPH_RESET))
    else $error("peripheral write landed wrongly");
  wr_port_a: assert property (s_port_wr |=> pt == ((($past(reg_wdata) & $past(port_presence_mask))
    | ($past(pt) & ~$past(port_presence_mask))) & PSR_IMPL_PORT_RESET))
    else $error("port write landed wrongly");
  rd_periph_a: assert property (reg_rd && reg_addr == PSR_OFF_PERIPH_RESET |=> reg_rdata == $past(pv))
    else $error("peripheral readback wrong");
  rd_port_a: assert property (reg_rd && reg_addr == PSR_OFF_PORT_RESET |=> reg_rdata == $past(pt))
    else $error("port readback wrong");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == PSR_RDATA_IDLE)
    else $error("read data outside read slot");
  hold_lines_a: assert property (!reg_wr |=> $stable({pv, pt}))
    else $error("reset lines moved without write");
  wr_other_a: assert property (reg_wr && reg_addr != PSR_OFF_PERIPH_RESET && reg_addr != PSR_OFF_PORT_RESET
    |=> $stable({pv, pt}))
    else $error("stray write changed reset lines");
  rst_clear_a: assert property ($rose(rst_n) |-> {pv, pt} == 64'h0)
    else $error("reset lines not clear after reset");
endmodule : psr_ctrl_monitor
bind psr_ctrl psr_ctrl_monitor u_psr_ctrl_monitor (.*);
`default_nettype wire

// file: dv/tb_psr_ctrl.sv
// Self-checking testbench of the peripheral soft reset block.
`default_nettype none
module tb_psr_ctrl;
  import psr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, pend = 0, run = 0;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, peripheral_presence_mask = '1, port_presence_mask = '1, reg_rdata;
  logic comparator_zero_reset, gp_counter_zero_reset, gp_counter_one_reset, gp_counter_two_reset;
  logic two_wire_zero_reset, sync_serial_zero_reset, async_serial_zero_reset, async_serial_one_reset;
  logic port_a_reset, port_b_reset, port_c_reset, port_d_reset, port_e_reset;
  logic [31:0] ep = '0, et = '0, rexp = '0;
  int err_count = 0, samples_checked = 0, cyc = 0;
  psr_ctrl u_psr_ctrl (.*);
  wire logic [31:0] pv = {7'h0, comparator_zero_reset, 5'h0, gp_counter_two_reset, gp_counter_one_reset,
    gp_counter_zero_reset, 3'h0, two_wire_zero_reset, 7'h0, sync_serial_zero_reset, 2'h0,
    async_serial_one_reset, async_serial_zero_reset};
  wire logic [31:0] pt = {27'h0, port_e_reset, port_d_reset, port_c_reset, port_b_reset, port_a_reset};
  initial forever #50 clk_sys = ~clk_sys;
  // ****
  // Checking and bus helpers.
  // ****
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] view(input logic [11:0] a);
    case (a)
      PSR_OFF_PERIPH_RESET: return ep;
      PSR_OFF_PORT_RESET:   return et;
      PSR_OFF_PERIPH_CAPS:  return peripheral_presence_mask & PSR_IMPL_PERIPH_RESET;
      PSR_OFF_PORT_CAPS:    return port_presence_mask & PSR_IMPL_PORT_RESET;
      default:              return 32'h0000_0000;
    endcase
  endfunction : view
  // One bus cycle; strobes are left up so accesses can run back to back, the model follows writes.
  task acc(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] m;
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    pend <= r;
    rexp <= view(a);
    m = peripheral_presence_mask & PSR_IMPL_PERIPH_RESET;
    if (w && a == PSR_OFF_PERIPH_RESET) ep = (ep & ~m) | (d & m);
    m = port_presence_mask & PSR_IMPL_PORT_RESET;
    if (w && a == PSR_OFF_PORT_RESET) et = (et & ~m) | (d & m);
  endtask : acc
  // Lines and read data are judged mid-cycle, away from the edge that moves them.
  always @(negedge clk_sys) begin
    if (run && rst_n) begin
      chk(pv, ep);
      chk(pt, et);
      chk(reg_rdata, pend ? rexp : 32'h0000_0000);
    end
  end
  // ****
  // Scenarios.
  // ****
  task t_walk();
    for (int i = 0; i < 32; i++) begin
      acc(1, 0, PSR_OFF_PERIPH_RESET, 32'h1 << i);
      acc(0, 1, PSR_OFF_PERIPH_RESET, 32'h0);
      acc(1, 0, PSR_OFF_PORT_RESET, 32'h1 << i);
      acc(0, 1, PSR_OFF_PORT_RESET, 32'h0);
    end
  endtask : t_walk
  task t_masked();
    peripheral_presence_mask <= 32'h0101_0002;
    port_presence_mask <= 32'h0000_0005;
    acc(1, 0, PSR_OFF_PERIPH_RESET, 32'hFFFF_FFFF);
    acc(1, 0, PSR_OFF_PORT_RESET, 32'hFFFF_FFFF);
    acc(0, 1, PSR_OFF_PERIPH_CAPS, 32'h0);
    peripheral_presence_mask <= 32'h0000_0012;
    port_presence_mask <= 32'h0000_0004;
    acc(1, 0, PSR_OFF_PERIPH_RESET, ep & 32'hFFFF_FFED);
    acc(1, 0, PSR_OFF_PORT_RESET, 32'h0);
    acc(0, 1, PSR_OFF_PORT_CAPS, 32'h0);
    acc(0, 1, PSR_OFF_PERIPH_RESET, 32'h0);
  endtask : t_masked
  task t_stray();
    peripheral_presence_mask <= '1;
    port_presence_mask <= '1;
    acc(1, 0, 12'h04C, 32'hFFFF_FFFF);
    acc(1, 0, 12'h844, 32'hFFFF_FFFF);
    acc(1, 0, PSR_OFF_PERIPH_CAPS, 32'hFFFF_FFFF);
    acc(0, 1, 12'h040, 32'h0);
    acc(0, 1, 12'h848, 32'h0);
  endtask : t_stray
  task t_midreset();
    acc(1, 0, PSR_OFF_PORT_RESET, 32'h0000_001F);
    acc(0, 0, 12'h000, 32'h0);
    rst_n <= 0;
    repeat (2) @(posedge clk_sys);
    ep = '0;
    et = '0;
    rst_n <= 1;
    // The first request waits one edge past the release, as the reset contract allows.
    @(posedge clk_sys);
    acc(0, 1, PSR_OFF_PERIPH_RESET, 32'h0);
    acc(0, 1, PSR_OFF_PORT_RESET, 32'h0);
    acc(0, 0, 12'h000, 32'h0);
  endtask : t_midreset
  // ****
  // Closing and main sequence.
  // ****
  task test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // Generous ceiling: the sequence needs fewer than two hundred cycles.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1;
    run <= 1;
    @(posedge clk_sys);
    acc(0, 1, PSR_OFF_PERIPH_RESET, 32'h0);
    acc(0, 1, PSR_OFF_PORT_RESET, 32'h0);
    t_walk();
    t_masked();
    t_stray();
    t_midreset();
    repeat (2) @(posedge clk_sys);
    test_done();
  end
endmodule : tb_psr_ctrl
`default_nettype wire
